// *** gbcs_pkg.sv ***
// gbcs_pkg: constants for the gpib bus line control / status register bank.
// assumes an avalon-mm word-addressed slave port and a 100 mhz core clock.

package gbcs_pkg;

   // -----------------------------------------------------------------
   // register word addresses
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] REG_BUS_LINE_CONTROL  = 4'h0;
   localparam logic [3:0] REG_BUS_LINE_STATUS   = 4'h1;
   localparam logic [3:0] REG_TALKER_OUTPUT_BYTE = 4'h2;
   localparam logic [3:0] REG_CONFIG            = 4'h3;
   localparam logic [3:0] REG_INT_STATUS        = 4'h4;
   localparam logic [3:0] REG_INT_CLEAR         = 4'h5;
   localparam logic [3:0] REG_INT_ENABLE        = 4'h6;
   localparam logic [3:0] REG_AUX_CMD           = 4'h7;
   localparam logic [3:0] REG_DATA_IN           = 4'h8;
   localparam logic [3:0] REG_CMD_PASS          = 4'h9;

   // -----------------------------------------------------------------
   // gpib control line positions
   // -----------------------------------------------------------------
   localparam int unsigned LN_ATN  = 7;
   localparam int unsigned LN_DAV  = 6;
   localparam int unsigned LN_NDAC = 5;
   localparam int unsigned LN_NRFD = 4;
   localparam int unsigned LN_EOI  = 3;
   localparam int unsigned LN_SRQ  = 2;
   localparam int unsigned LN_IFC  = 1;
   localparam int unsigned LN_REN  = 0;
   localparam logic [7:0] MON_MASK = 8'h34;

   // -----------------------------------------------------------------
   // interrupt flag positions
   // -----------------------------------------------------------------
   localparam int unsigned N_FLAGS = 17;
   localparam int unsigned FL_ADDRESS_STATUS_CHANGE = 0;
   localparam int unsigned FL_APT  = 1;
   localparam int unsigned FL_ATTENTION_INTERRUPT = 2;
   localparam int unsigned FL_CO   = 3;
   localparam int unsigned FL_CPT  = 4;
   localparam int unsigned FL_DEC  = 5;
   localparam int unsigned FL_DET  = 6;
   localparam int unsigned FL_DI   = 7;
   localparam int unsigned FL_DO   = 8;
   localparam int unsigned FL_END  = 9;
   localparam int unsigned FL_ERR  = 10;
   localparam int unsigned FL_INTERFACE_CLEAR_RECEIVED = 11;
   localparam int unsigned FL_LOCKOUT_CHANGE = 12;
   localparam int unsigned FL_REMOTE_CHANGE = 13;
   localparam int unsigned FL_SERVICE_REQUEST_RECEIVED = 14;
   localparam int unsigned FL_STATUS_BYTE_OUT = 15;
   localparam int unsigned FL_SYNC = 16;
   localparam logic [16:0] MODE_FREE_MASK = 17'h18000;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int unsigned CFG_STATIC  = 0;
   localparam int unsigned CFG_HOLDOFF = 1;
   localparam int unsigned AUX_VALID    = 0;
   localparam int unsigned AUX_NONVALID = 1;
   localparam logic [7:0]  RST_BUS_LINE_CONTROL = 8'h00;
   localparam logic [7:0]  RST_OUTPUT_BYTE = 8'h00;
   localparam logic [1:0]  RST_CONFIG = 2'h0;
   localparam logic [16:0] RST_INT_ENABLE = 17'h00000;

endpackage

// *** gbcs_sync3.sv ***
// gbcs_sync3: three-stage input synchroniser with agreement filter.
// assumes an asynchronous level input and an active-low synced reset.
`timescale 1ns/1ps
`default_nettype none

module gbcs_sync3 (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   input  wire logic async_in,
   output var  logic sync_out
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q     <= 1'b0;
         s2_q     <= 1'b0;
         s3_q     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // change accepted only once stages two and three agree
         if (s2_q == s3_q) begin
            sync_out <= s3_q;
         end
      end
   end

endmodule
`default_nettype wire

// *** gbcs_flag.sv ***
// gbcs_flag: one sticky interrupt status flag.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module gbcs_flag (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   output var  logic flag_out
);

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_out <= 1'b0;
      end else begin
         flag_out <= set_in | (flag_out & ~clr_in);
      end
   end

endmodule
`default_nettype wire

// *** gbcs_top.sv ***
// gbcs_top: gpib bus line control/status, output byte and interrupt flags.
// assumes interface functions on the same clock and control lines arriving
// asynchronously from the transceivers; asserted lines are 1 here.
`timescale 1ns/1ps
`default_nettype none

module gbcs_top #(
   parameter int unsigned N_LINES = 8
) (
   input  wire logic        core_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output var  logic [31:0] avs_readdata_out,
   output var  logic        avs_waitrequest_out,
   input  wire logic [7:0]  line_in,
   output var  logic [7:0]  line_out,
   output var  logic [7:0]  line_oe_n_out,
   input  wire logic [7:0]  fn_drive_in,
   input  wire logic [7:0]  xmit_en_in,
   output var  logic [7:0]  line_seen_out,
   input  wire logic [16:0] event_in,
   input  wire logic        ton_in,
   input  wire logic        lon_in,
   input  wire logic        controller_active_state_in,
   input  wire logic        source_generate_state_in,
   input  wire logic        talker_active_state_in,
   input  wire logic        handshake_done_in,
   input  wire logic [7:0]  data_in_byte_in,
   input  wire logic [7:0]  cmd_pass_byte_in,
   input  wire logic        byte_taken_in,
   output var  logic        nba_out,
   output var  logic [7:0]  output_byte_out,
   output var  logic        valid_out,
   output var  logic        nonvalid_out,
   output var  logic        holdoff_mode_out,
   output var  logic        irq_out
);

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   if (N_LINES != 8) begin : g_bad_lines
      $error("gbcs_top: only eight control lines are supported");
   end

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_pipe_q;
   logic       rst_n;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_pipe_q <= 2'b00;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   // -----------------------------------------------------------------
   // avalon-mm slave: one wait cycle, access on the waitrequest-low edge
   // -----------------------------------------------------------------
   function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   logic        req;
   logic        rd_fire;
   logic        wr_fire;
   logic [31:0] rd_d;
   logic [16:0] flags;
   logic [16:0] en_q;
   logic [1:0]  cfg_q;
   logic [7:0]  bcr_q;

   assign req     = avs_read_in | avs_write_in;
   assign rd_fire = avs_read_in & ~avs_waitrequest_out;
   assign wr_fire = avs_write_in & ~avs_waitrequest_out;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest_out <= 1'b1;
      end else if (req && !avs_waitrequest_out) begin
         avs_waitrequest_out <= 1'b1;
      end else if (req) begin
         avs_waitrequest_out <= 1'b0;
      end
   end

   always_comb begin
      rd_d = 32'h00000000;
      if (is_reg(avs_address_in, gbcs_pkg::REG_BUS_LINE_STATUS)) begin
         rd_d[7:0] = line_seen_out;
      end else if (is_reg(avs_address_in, gbcs_pkg::REG_CONFIG)) begin
         rd_d[1:0] = cfg_q;
      end else if (is_reg(avs_address_in, gbcs_pkg::REG_INT_STATUS)) begin
         rd_d[16:0] = flags;
      end else if (is_reg(avs_address_in, gbcs_pkg::REG_INT_ENABLE)) begin
         rd_d[16:0] = en_q;
      end else if (is_reg(avs_address_in, gbcs_pkg::REG_DATA_IN)) begin
         rd_d[7:0] = data_in_byte_in;
      end else if (is_reg(avs_address_in, gbcs_pkg::REG_CMD_PASS)) begin
         rd_d[7:0] = cmd_pass_byte_in;
      end
   end

   // data captured in the wait cycle, so status is that of the read itself
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata_out <= 32'h00000000;
      end else if (avs_read_in && avs_waitrequest_out) begin
         avs_readdata_out <= rd_d;
      end
   end

   // -----------------------------------------------------------------
   // software registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         bcr_q <= gbcs_pkg::RST_BUS_LINE_CONTROL;
      end else if (wr_fire &&
                   is_reg(avs_address_in, gbcs_pkg::REG_BUS_LINE_CONTROL)) begin
         bcr_q <= avs_writedata_in[7:0];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= gbcs_pkg::RST_CONFIG;
      end else if (wr_fire && is_reg(avs_address_in, gbcs_pkg::REG_CONFIG)) begin
         cfg_q <= avs_writedata_in[1:0];
      end
   end
   assign holdoff_mode_out = cfg_q[gbcs_pkg::CFG_HOLDOFF];

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= gbcs_pkg::RST_INT_ENABLE;
      end else if (wr_fire &&
                   is_reg(avs_address_in, gbcs_pkg::REG_INT_ENABLE)) begin
         en_q <= avs_writedata_in[16:0];
      end
   end

   logic aux_wr;
   assign aux_wr = wr_fire && is_reg(avs_address_in, gbcs_pkg::REG_AUX_CMD);

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         valid_out    <= 1'b0;
         nonvalid_out <= 1'b0;
      end else begin
         valid_out    <= aux_wr && avs_writedata_in[gbcs_pkg::AUX_VALID];
         nonvalid_out <= aux_wr && avs_writedata_in[gbcs_pkg::AUX_NONVALID];
      end
   end

   // -----------------------------------------------------------------
   // talker output byte and nba
   // -----------------------------------------------------------------
   logic out_wr;
   logic nba_set;

   assign out_wr  = wr_fire &&
                    is_reg(avs_address_in, gbcs_pkg::REG_TALKER_OUTPUT_BYTE);
   assign nba_set = out_wr && (talker_active_state_in || controller_active_state_in);

   // input data latch is a separate path and is never touched here
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         output_byte_out <= gbcs_pkg::RST_OUTPUT_BYTE;
      end else if (out_wr) begin
         output_byte_out <= avs_writedata_in[7:0];
      end
   end

   // a new write wins over the source handshake taking the old byte
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         nba_out <= 1'b0;
      end else begin
         nba_out <= nba_set | (nba_out & ~byte_taken_in);
      end
   end

   // -----------------------------------------------------------------
   // control lines
   // -----------------------------------------------------------------
   logic [7:0] pin_s;

   for (genvar i = 0; i < N_LINES; i++) begin : g_line_sync
      gbcs_sync3 u_sync (
         .core_clk_in (core_clk_in),
         .rst_n_in    (rst_n),
         .async_in    (line_in[i]),
         .sync_out    (pin_s[i])
      );
   end

   // transceiver loopback: driven lines return the own value on line_in
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         line_seen_out <= 8'h00;
      end else begin
         line_seen_out <= pin_s | bcr_q
                        | (fn_drive_in & gbcs_pkg::MON_MASK);
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         line_out      <= 8'h00;
         line_oe_n_out <= 8'hFF;
      end else begin
         line_out      <= xmit_en_in & (fn_drive_in | bcr_q);
         line_oe_n_out <= ~xmit_en_in;
      end
   end

   // -----------------------------------------------------------------
   // interrupt flags
   // -----------------------------------------------------------------
   logic        ton_q;
   logic        lon_q;
   logic        stat_mode;
   logic        stat_rd;
   logic [16:0] clr_cmd;
   logic [16:0] clr;

   assign stat_mode = cfg_q[gbcs_pkg::CFG_STATIC];
   assign stat_rd   = rd_fire &&
                      is_reg(avs_address_in, gbcs_pkg::REG_INT_STATUS);
   assign clr_cmd   = (wr_fire &&
                       is_reg(avs_address_in, gbcs_pkg::REG_INT_CLEAR)) ?
                      avs_writedata_in[16:0] : 17'h00000;

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ton_q <= 1'b0;
         lon_q <= 1'b0;
      end else begin
         ton_q <= ton_in;
         lon_q <= lon_in;
      end
   end

   always_comb begin
      clr = clr_cmd;
      if (stat_mode) begin
         clr[gbcs_pkg::FL_ADDRESS_STATUS_CHANGE] = clr_cmd[gbcs_pkg::FL_ADDRESS_STATUS_CHANGE]
                                | (ton_in & ~ton_q) | (lon_in & ~lon_q);
         clr[gbcs_pkg::FL_APT]  = valid_out | nonvalid_out;
         clr[gbcs_pkg::FL_CPT]  = rd_fire &&
                                  is_reg(avs_address_in, gbcs_pkg::REG_CMD_PASS);
         clr[gbcs_pkg::FL_CO]   = ~controller_active_state_in | ~source_generate_state_in | nba_set;
         clr[gbcs_pkg::FL_DI]   = (rd_fire &&
                                   is_reg(avs_address_in, gbcs_pkg::REG_DATA_IN))
                                | (handshake_done_in &
                                   cfg_q[gbcs_pkg::CFG_HOLDOFF]);
         clr[gbcs_pkg::FL_DO]   = ~talker_active_state_in | ~source_generate_state_in | nba_set;
      end else if (stat_rd) begin
         // only bits software actually saw are cleared by the read
         clr = clr_cmd | (avs_readdata_out[16:0] & ~gbcs_pkg::MODE_FREE_MASK);
      end
      // mode-free flags obey only their own clear command
      clr[gbcs_pkg::FL_STATUS_BYTE_OUT] = clr_cmd[gbcs_pkg::FL_STATUS_BYTE_OUT];
      clr[gbcs_pkg::FL_SYNC] = clr_cmd[gbcs_pkg::FL_SYNC];
      clr[gbcs_pkg::FL_DO]   = clr[gbcs_pkg::FL_DO] | nba_set;
   end

   for (genvar f = 0; f < gbcs_pkg::N_FLAGS; f++) begin : g_flag
      gbcs_flag u_flag (
         .core_clk_in (core_clk_in),
         .rst_n_in    (rst_n),
         .set_in      (event_in[f]),
         .clr_in      (clr[f]),
         .flag_out    (flags[f])
      );
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(flags & en_q);
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n);

   sequence s_byte_write;
      nba_set;
   endsequence

   sequence s_status_read;
      avs_read_in && avs_waitrequest_out &&
      is_reg(avs_address_in, gbcs_pkg::REG_BUS_LINE_STATUS);
   endsequence

   property p_static_hold;
      stat_mode && flags[gbcs_pkg::FL_ATTENTION_INTERRUPT] && !clr_cmd[gbcs_pkg::FL_ATTENTION_INTERRUPT]
      |=> flags[gbcs_pkg::FL_ATTENTION_INTERRUPT];
   endproperty
   a_static_hold: assert property (p_static_hold)
      else $error("atn flag lost in static mode");

   property p_address_status_change_clear;
      stat_mode && ton_in && !ton_q && !event_in[gbcs_pkg::FL_ADDRESS_STATUS_CHANGE]
      |=> !flags[gbcs_pkg::FL_ADDRESS_STATUS_CHANGE];
   endproperty
   a_address_status_change_clear: assert property (p_address_status_change_clear)
      else $error("address status change not cleared by ton");

   property p_apt_clear;
      stat_mode && aux_wr && avs_writedata_in[gbcs_pkg::AUX_VALID]
      |=> ##1 (!flags[gbcs_pkg::FL_APT] ||
               $past(event_in[gbcs_pkg::FL_APT]) || !stat_mode);
   endproperty
   a_apt_clear: assert property (p_apt_clear)
      else $error("address pass-through not cleared by valid");

   property p_co_clear;
      stat_mode && !controller_active_state_in && !event_in[gbcs_pkg::FL_CO]
      |=> !flags[gbcs_pkg::FL_CO];
   endproperty
   a_co_clear: assert property (p_co_clear)
      else $error("instruction byte ready held outside controller state");

   property p_di_clear;
      stat_mode && cfg_q[gbcs_pkg::CFG_HOLDOFF] && handshake_done_in &&
      !event_in[gbcs_pkg::FL_DI] |=> !flags[gbcs_pkg::FL_DI];
   endproperty
   a_di_clear: assert property (p_di_clear)
      else $error("data-in not cleared by holdoff handshake");

   property p_do_clear;
      stat_mode && !talker_active_state_in && !event_in[gbcs_pkg::FL_DO]
      |=> !flags[gbcs_pkg::FL_DO];
   endproperty
   a_do_clear: assert property (p_do_clear)
      else $error("byte-out held outside talker state");

   property p_status_byte_out_mode_free;
      flags[gbcs_pkg::FL_STATUS_BYTE_OUT] && !clr_cmd[gbcs_pkg::FL_STATUS_BYTE_OUT]
      |=> flags[gbcs_pkg::FL_STATUS_BYTE_OUT];
   endproperty
   a_status_byte_out_mode_free: assert property (p_status_byte_out_mode_free)
      else $error("status byte out flag cleared without its command");

   property p_status_read;
      s_status_read |=> !avs_waitrequest_out &&
         avs_readdata_out[7:0] == $past(line_seen_out);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("bus status read does not show current lines");

   property p_bcr_or;
      1'b1 |=> ((line_seen_out & $past(bcr_q)) == $past(bcr_q));
   endproperty
   a_bcr_or: assert property (p_bcr_or)
      else $error("bus control bit not seen on internal line");

   property p_no_drive_rx;
      1'b1 |=> ((line_out & (line_oe_n_out | ~$past(xmit_en_in))) == 8'h00);
   endproperty
   a_no_drive_rx: assert property (p_no_drive_rx)
      else $error("line driven while receiving");

   property p_nba_set;
      s_byte_write |=> nba_out &&
         output_byte_out == $past(avs_writedata_in[7:0]);
   endproperty
   a_nba_set: assert property (p_nba_set)
      else $error("output byte write did not raise nba");

endmodule
`default_nettype wire

// *** gbcs_bus_model.sv ***
// gbcs_bus_model: far-side instruments sharing the gpib control lines.
// assumes 1 = asserted; transceivers and pull-ups sit outside.
`timescale 1ns/1ps
`default_nettype none

module gbcs_bus_model (
   input  wire logic [7:0] ext_assert_in,
   input  wire logic [7:0] dut_line_in,
   input  wire logic [7:0] dut_oe_n_in,
   output var  logic [7:0] bus_line_out
);
   // wired-or bus; a released line falls back to unasserted via pull-up
   assign bus_line_out = ext_assert_in | (dut_line_in & ~dut_oe_n_in);
endmodule

`default_nettype wire

// *** gbcs_top_tb.sv ***
// gbcs_top_tb: register-level bench for the line control/status bank.
// assumes gbcs_bus_model plays the other instruments on the lines.
`timescale 1ns/1ps
`default_nettype none

module gbcs_top_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0, wr = 1'b0, wait_r;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [7:0]  lin, lout, loe_n, seen, obyte;
   logic [7:0]  fn = 8'h00, xe = 8'h00, ext = 8'h00;
   logic [16:0] ev = 17'h0;
   logic        ton = 1'b0, lon = 1'b0, hs = 1'b0, taken = 1'b0;
   logic        controller_active_state = 1'b1, source_generate_state = 1'b1, talker_active_state = 1'b1;
   logic        nba, val, nval, hold, irq;
   int          errors = 0, checks_done = 0;

   initial forever #5 clk = ~clk;

   gbcs_bus_model i_bus (.ext_assert_in(ext), .dut_line_in(lout),
      .dut_oe_n_in(loe_n), .bus_line_out(lin));

   gbcs_top #(.N_LINES(8)) i_dut (.core_clk_in(clk), .arst_n_in(rst_n),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wd), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wait_r), .line_in(lin), .line_out(lout),
      .line_oe_n_out(loe_n), .fn_drive_in(fn), .xmit_en_in(xe),
      .line_seen_out(seen), .event_in(ev), .ton_in(ton), .lon_in(lon),
      .controller_active_state_in(controller_active_state), .source_generate_state_in(source_generate_state), .talker_active_state_in(talker_active_state),
      .handshake_done_in(hs), .data_in_byte_in(8'hC3),
      .cmd_pass_byte_in(8'h3C), .byte_taken_in(taken), .nba_out(nba),
      .output_byte_out(obyte), .valid_out(val), .nonvalid_out(nval),
      .holdoff_mode_out(hold), .irq_out(irq));

   // ----------------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_r !== 1'b0 && n < 20);
      chk({31'h0, wait_r}, 32'h0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic st(input logic [16:0] e);
      bus(1'b0, 4'h4, 32'h0);
      chk(q, {15'h0, e});
   endtask

   task automatic pulse(input logic [16:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 17'h0;
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 4'h0, 32'h1 << i);
         bus(1'b0, 4'h1, 32'h0);
         chk(q, 32'h1 << i);
         chk({24'h0, lout}, 32'h0);
      end
      xe <= 8'hFF;
      bus(1'b1, 4'h0, 32'h84);
      repeat (2) @(posedge clk);
      chk({24'h0, lout, loe_n}, 32'h8400);
      bus(1'b0, 4'h1, 32'h0);
      chk(q, 32'h84);
      bus(1'b1, 4'h0, 32'h0);
      xe <= 8'h00;
      ext <= 8'h01;
      repeat (6) @(posedge clk);
      bus(1'b0, 4'h1, 32'h0);
      chk(q, 32'h01);
      ext <= 8'h00;
      fn <= 8'h04;
      repeat (6) @(posedge clk);
      chk({24'h0, seen}, 32'h04);
      fn <= 8'h00;
      bus(1'b0, 4'hF, 32'h0);
      chk(q, 32'h0);
      pulse(17'h4);
      st(17'h4);
      st(17'h0);
      bus(1'b1, 4'h3, 32'h1);
      pulse(17'h4);
      st(17'h4);
      st(17'h4);
      bus(1'b1, 4'h5, 32'h4);
      st(17'h0);
      pulse(17'h1);
      st(17'h1);
      ton <= 1'b1;
      st(17'h0);
      pulse(17'h1);
      lon <= 1'b1;
      st(17'h0);
      for (int i = 1; i < 3; i++) begin
         pulse(17'h2);
         bus(1'b1, 4'h7, i);
         @(posedge clk);
         chk({30'h0, nval, val}, i);
         st(17'h0);
      end
      pulse(17'h108);
      st(17'h108);
      bus(1'b1, 4'h2, 32'h5A);
      st(17'h0);
      chk({23'h0, nba, obyte}, 32'h15A);
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'hC3);
      pulse(17'h108);
      source_generate_state <= 1'b0;
      st(17'h0);
      source_generate_state <= 1'b1;
      pulse(17'h108);
      controller_active_state <= 1'b0;
      talker_active_state <= 1'b0;
      taken <= 1'b1;
      st(17'h0);
      taken <= 1'b0;
      bus(1'b1, 4'h2, 32'hA5);
      @(posedge clk);
      chk({23'h0, nba, obyte}, 32'h0A5);
      controller_active_state <= 1'b1;
      talker_active_state <= 1'b1;
      pulse(17'h80);
      st(17'h80);
      bus(1'b0, 4'h8, 32'h0);
      st(17'h0);
      bus(1'b1, 4'h3, 32'h3);
      pulse(17'h80);
      hs <= 1'b1;
      @(posedge clk);
      hs <= 1'b0;
      chk({31'h0, hold}, 32'h1);
      st(17'h0);
      pulse(17'h10);
      bus(1'b0, 4'h9, 32'h0);
      st(17'h0);
      pulse(17'h8000);
      bus(1'b1, 4'h3, 32'h0);
      st(17'h8000);
      st(17'h8000);
      bus(1'b1, 4'h5, 32'h8000);
      bus(1'b1, 4'h6, 32'h4);
      pulse(17'h4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 4'h5, 32'h4);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      finish_test;
   end

   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      finish_test;
   end
endmodule

`default_nettype wire
